// >>> include/rpc_pkg.sv
// constants, field layout and carrier types for the fourth-input priority bank
// assumes one 100 MHz clock and a byte-wide register access port in the same domain
// How it works
// - a four-bit priority is kept for the fourth reference input, a smaller nonzero value ranking it higher.
// - a priority of zero takes the fourth reference input out of automatic selection.
// - with the path target select bit clear, the priority field reads and writes the main path value.
// - with the path target select bit set, the priority field reads and writes a separate auxiliary path value.
// - a two-bit field picks which of four leaky bucket configurations the activity monitor uses.
package rpc_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam int          PRIO_W          = 4;
	// register offsets
	localparam logic [7:0]  OFS_PRIO4       = 8'h19;
	localparam logic [7:0]  OFS_FREQ_CFG    = 8'h22;
	localparam logic [7:0]  OFS_SRC_SEL     = 8'h4b;
	// field positions
	localparam int          SRC_SEL_PATH_B  = 4;
	localparam int          CFG_PREDIV_B    = 7;
	localparam int          CFG_LOCK8K_B    = 6;
	localparam int          CFG_BUCKET_LO   = 4;
	localparam int          CFG_FREQ_LO     = 0;
	// values after reset
	localparam logic [3:0]  PRIO_MAIN_RST   = 4'h5;
	localparam logic [3:0]  PRIO_AUX_RST    = 4'h0;
	localparam logic [7:0]  FREQ_CFG_RST    = 8'h00;
	localparam logic        PATH_SEL_RST    = 1'b0;
	// read answer latency in cycles
	localparam int          RD_LAT          = 1;

	typedef struct packed {
		logic       input_predivide_enable;
		logic       lock_at_8k_enable;
		logic [1:0] activity_bucket_config_select;
		logic [3:0] freq_code;
	} rpc_cfg_t;

	typedef struct packed {
		logic [3:0] prio;
		logic       eligible;
	} rpc_path_prio_t;
endpackage

// >>> logic/rpc_ref_route.sv
// reference routing stage: picks direct or pre-divided input, registered
// assumes both reference samples are synchronous to clk
module rpc_ref_route (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// control
	input  wire logic predivide_en,
	// reference samples
	input  wire logic ref_direct,
	input  wire logic ref_predivided,
	// routed reference
	output logic      ref_routed_r
);
	logic ref_routed_nxt;

	always_comb begin
		ref_routed_nxt = predivide_en ? ref_predivided : ref_direct;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_routed_r <= 1'b0;
		end else begin
			ref_routed_r <= ref_routed_nxt;
		end
	end
endmodule

// >>> logic/rpc_top.sv
// fourth-input priority and input configuration registers
// assumes a byte register port driven synchronously to clk; one access per cycle
module rpc_top (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// register access port
	input  wire logic [7:0]               reg_addr,
	input  wire logic                     reg_wr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_rd,
	output logic [7:0]                    reg_rdata_r,
	output logic                          reg_rvalid_r,
	// reference samples
	input  wire logic                     ref_in,
	input  wire logic                     ref_predivided,
	// configuration to selection and monitoring
	output rpc_pkg::rpc_path_prio_t       main_prio_r,
	output rpc_pkg::rpc_path_prio_t       aux_prio_r,
	output rpc_pkg::rpc_cfg_t             input_cfg_r,
	output logic                          path_priority_target_select_r,
	output logic                          ref_to_dpll_r
);
	logic [3:0] prio_main_r;
	logic [3:0] prio_aux_r;
	logic [7:0] rdata_nxt;
	logic       wr_prio;
	logic       wr_cfg;
	logic       wr_sel;

	// the select bit picks which path's copy the shared field window shows
	function automatic logic [3:0] sel_prio(input logic sel, input logic [3:0] m,
		input logic [3:0] a);
		sel_prio = sel ? a : m;
	endfunction

	assign wr_prio = reg_wr && (reg_addr == rpc_pkg::OFS_PRIO4);
	assign wr_cfg  = reg_wr && (reg_addr == rpc_pkg::OFS_FREQ_CFG);
	assign wr_sel  = reg_wr && (reg_addr == rpc_pkg::OFS_SRC_SEL);

	// path target select
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			path_priority_target_select_r <= rpc_pkg::PATH_SEL_RST;
		end else if (wr_sel) begin
			path_priority_target_select_r <= reg_wdata[rpc_pkg::SRC_SEL_PATH_B];
		end
	end

	// per-path priority copies; upper nibble of the write is dropped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prio_main_r <= rpc_pkg::PRIO_MAIN_RST;
			prio_aux_r  <= rpc_pkg::PRIO_AUX_RST;
		end else if (wr_prio) begin
			if (path_priority_target_select_r) begin
				prio_aux_r <= reg_wdata[3:0];
			end else begin
				prio_main_r <= reg_wdata[3:0];
			end
		end
	end

	// values and eligibility seen by the selector, one cycle behind the store
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			main_prio_r <= '0;
			aux_prio_r  <= '0;
		end else begin
			main_prio_r.prio     <= prio_main_r;
			aux_prio_r.prio      <= prio_aux_r;
			main_prio_r.eligible <= |prio_main_r;
			aux_prio_r.eligible  <= |prio_aux_r;
		end
	end

	// input frequency and monitor configuration
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			input_cfg_r <= rpc_pkg::rpc_cfg_t'(rpc_pkg::FREQ_CFG_RST);
		end else if (wr_cfg) begin
			input_cfg_r <= rpc_pkg::rpc_cfg_t'(reg_wdata);
		end
	end

	// read mux; unmapped offsets and unused bits read zero
	always_comb begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			rpc_pkg::OFS_PRIO4: begin
				rdata_nxt = {4'h0, sel_prio(path_priority_target_select_r,
					prio_main_r, prio_aux_r)};
			end
			rpc_pkg::OFS_FREQ_CFG: begin
				rdata_nxt = input_cfg_r;
			end
			rpc_pkg::OFS_SRC_SEL: begin
				rdata_nxt[rpc_pkg::SRC_SEL_PATH_B] = path_priority_target_select_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_r  <= 8'h00;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_rd;
			if (reg_rd) begin
				reg_rdata_r <= rdata_nxt;
			end
		end
	end

	rpc_ref_route u_route (
		.clk            (clk),
		.reset_n        (reset_n),
		.predivide_en   (input_cfg_r.input_predivide_enable),
		.ref_direct     (ref_in),
		.ref_predivided (ref_predivided),
		.ref_routed_r   (ref_to_dpll_r)
	);

	// checks
	property p_main_write;
		@(posedge clk) disable iff (!reset_n)
		(wr_prio && !path_priority_target_select_r) |=> ##1
			(main_prio_r.prio == $past(reg_wdata[3:0], 2)) && $stable(aux_prio_r.prio);
	endproperty
	a_main_write: assert property (p_main_write) else $error("main priority write lost");

	property p_aux_write;
		@(posedge clk) disable iff (!reset_n)
		(wr_prio && path_priority_target_select_r) |=> ##1
			(aux_prio_r.prio == $past(reg_wdata[3:0], 2)) && $stable(main_prio_r.prio);
	endproperty
	a_aux_write: assert property (p_aux_write) else $error("aux priority write lost");

	property p_prio_read;
		@(posedge clk) disable iff (!reset_n)
		(reg_rd && !reg_wr && reg_addr == rpc_pkg::OFS_PRIO4) |=> reg_rvalid_r &&
			(reg_rdata_r == {4'h0, ($past(path_priority_target_select_r) ?
			$past(prio_aux_r) : $past(prio_main_r))});
	endproperty
	a_prio_read: assert property (p_prio_read) else $error("priority read wrong path");

	property p_prio_hold;
		@(posedge clk) disable iff (!reset_n)
		!wr_prio |=> $stable(prio_main_r) && $stable(prio_aux_r);
	endproperty
	a_prio_hold: assert property (p_prio_hold) else $error("priority changed unwritten");

	property p_eligible;
		@(posedge clk) disable iff (!reset_n)
		(prio_main_r == 4'h0) |=> !main_prio_r.eligible;
	endproperty
	a_eligible: assert property (p_eligible) else $error("zero priority still eligible");

	property p_eligible_aux;
		@(posedge clk) disable iff (!reset_n)
		(prio_aux_r != 4'h0) |=> aux_prio_r.eligible;
	endproperty
	a_eligible_aux: assert property (p_eligible_aux) else $error("nonzero aux not eligible");

	property p_route;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> ref_to_dpll_r == ($past(input_cfg_r.input_predivide_enable) ?
			$past(ref_predivided) : $past(ref_in));
	endproperty
	a_route: assert property (p_route) else $error("reference routed wrongly");

	property p_bucket;
		@(posedge clk) disable iff (!reset_n)
		wr_cfg |=> input_cfg_r.activity_bucket_config_select ==
			$past(reg_wdata[rpc_pkg::CFG_BUCKET_LO +: 2]);
	endproperty
	a_bucket: assert property (p_bucket) else $error("bucket select not stored");

	property p_predivide_field;
		@(posedge clk) disable iff (!reset_n)
		wr_cfg |=> input_cfg_r.input_predivide_enable ==
			$past(reg_wdata[rpc_pkg::CFG_PREDIV_B]);
	endproperty
	a_predivide_field: assert property (p_predivide_field) else $error("predivide not stored");

	property p_cfg_hold;
		@(posedge clk) disable iff (!reset_n)
		!wr_cfg |=> $stable(input_cfg_r);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unwritten");

	property p_cfg_read;
		@(posedge clk) disable iff (!reset_n)
		(reg_rd && !reg_wr && reg_addr == rpc_pkg::OFS_FREQ_CFG) |=> reg_rvalid_r &&
			(reg_rdata_r == $past(input_cfg_r));
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

	// the select bit steers every later priority access, so a lost write misroutes both paths
	property p_sel_write;
		@(posedge clk) disable iff (!reset_n)
		wr_sel |=> path_priority_target_select_r ==
			$past(reg_wdata[rpc_pkg::SRC_SEL_PATH_B]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select write lost");

	property p_sel_hold;
		@(posedge clk) disable iff (!reset_n)
		!wr_sel |=> $stable(path_priority_target_select_r);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select changed unwritten");

	property p_eligible_main_set;
		@(posedge clk) disable iff (!reset_n)
		(prio_main_r != 4'h0) |=> main_prio_r.eligible;
	endproperty
	a_eligible_main_set: assert property (p_eligible_main_set) else $error("nonzero main not eligible");

	property p_ineligible_aux;
		@(posedge clk) disable iff (!reset_n)
		(prio_aux_r == 4'h0) |=> !aux_prio_r.eligible;
	endproperty
	a_ineligible_aux: assert property (p_ineligible_aux) else $error("zero aux still eligible");

	property p_rdata_hold;
		@(posedge clk) disable iff (!reset_n)
		!reg_rd |=> $stable(reg_rdata_r) && !reg_rvalid_r;
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read answer without read");
endmodule

// >>> sim/rpc_top_bench.sv
// bench for the fourth-input priority and input configuration registers
// assumes rpc_top with its byte register port; inputs change on falling edges
module rpc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk = 1'b0;
	logic                    reset_n = 1'b0;
	logic [7:0]              reg_addr = 8'h00;
	logic                    reg_wr = 1'b0;
	logic [7:0]              reg_wdata = 8'h00;
	logic                    reg_rd = 1'b0;
	logic [7:0]              reg_rdata_r;
	logic                    reg_rvalid_r;
	logic                    ref_in = 1'b0;
	logic                    ref_predivided = 1'b0;
	rpc_pkg::rpc_path_prio_t main_prio_r;
	rpc_pkg::rpc_path_prio_t aux_prio_r;
	rpc_pkg::rpc_cfg_t       input_cfg_r;
	logic                    path_priority_target_select_r;
	logic                    ref_to_dpll_r;
	int                      err_total = 0;
	int                      n_checks = 0;
	int                      cycles = 0;

	always #5 clk = ~clk;

	rpc_top dut_u (
		.clk                           (clk),
		.reset_n                       (reset_n),
		.reg_addr                      (reg_addr),
		.reg_wr                        (reg_wr),
		.reg_wdata                     (reg_wdata),
		.reg_rd                        (reg_rd),
		.reg_rdata_r                   (reg_rdata_r),
		.reg_rvalid_r                  (reg_rvalid_r),
		.ref_in                        (ref_in),
		.ref_predivided                (ref_predivided),
		.main_prio_r                   (main_prio_r),
		.aux_prio_r                    (aux_prio_r),
		.input_cfg_r                   (input_cfg_r),
		.path_priority_target_select_r (path_priority_target_select_r),
		.ref_to_dpll_r                 (ref_to_dpll_r)
	);

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// the whole run takes about 75 cycles, so this ceiling only trips on a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			$display("mismatch at %0t: timeout", $time);
			finish_test();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// answer is registered one edge after the strobe, so it is settled at the next fall
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk({7'h00, reg_rvalid_r}, 8'h01, "rvalid");
		chk(reg_rdata_r, exp, "rdata");
	endtask

	initial begin
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		rd(8'h19, 8'h05);
		rd(8'h22, 8'h00);
		rd(8'h30, 8'h00);
		wr(8'h19, 8'hf3);
		@(negedge clk);
		chk({3'h0, main_prio_r}, 8'h07, "main prio");
		rd(8'h19, 8'h03);
		wr(8'h19, 8'h00);
		@(negedge clk);
		chk({3'h0, main_prio_r}, 8'h00, "main excluded");
		wr(8'h4b, 8'h10);
		rd(8'h19, 8'h00);
		wr(8'h19, 8'h07);
		@(negedge clk);
		chk({3'h0, aux_prio_r}, 8'h0f, "aux prio");
		chk({3'h0, main_prio_r}, 8'h00, "main kept");
		rd(8'h4b, 8'h10);
		wr(8'h4b, 8'h00);
		wr(8'h19, 8'h01);
		@(negedge clk);
		chk({3'h0, main_prio_r}, 8'h03, "main top");
		chk({3'h0, aux_prio_r}, 8'h0f, "aux kept");
		rd(8'h19, 8'h01);
		// predivide set: routed reference must follow the divided sample, not the raw one
		for (int i = 0; i < 4; i++) begin
			wr(8'h22, {2'b10, i[1:0], 4'h0});
			chk({6'h00, input_cfg_r.activity_bucket_config_select}, {6'h00, i[1:0]}, "bucket");
			ref_in = i[0];
			ref_predivided = ~i[0];
			@(negedge clk);
			chk({7'h00, ref_to_dpll_r}, {7'h00, ~i[0]}, "divided route");
		end
		wr(8'h22, 8'h3f);
		rd(8'h22, 8'h3f);
		ref_in = 1'b1;
		ref_predivided = 1'b0;
		@(negedge clk);
		chk({7'h00, ref_to_dpll_r}, 8'h01, "direct route");
		chk(input_cfg_r, 8'h3f, "cfg out");
		wr(8'h22, 8'hd9);
		chk(input_cfg_r, 8'hd9, "cfg lock8k");
		rd(8'h22, 8'hd9);
		// unmapped write must leave the priority copies alone
		wr(8'h30, 8'hff);
		rd(8'h19, 8'h01);
		rd(8'h30, 8'h00);
		wr(8'h4b, 8'hff);
		chk({7'h00, path_priority_target_select_r}, 8'h01, "select set");
		rd(8'h4b, 8'h10);
		rd(8'h19, 8'h07);
		// mid-run reset must restore every copy, the select bit too
		@(negedge clk);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		chk({7'h00, path_priority_target_select_r}, 8'h00, "select reset");
		chk({3'h0, main_prio_r}, 8'h0b, "main reset");
		chk({3'h0, aux_prio_r}, 8'h00, "aux reset");
		chk(input_cfg_r, 8'h00, "cfg reset");
		rd(8'h19, 8'h05);
		finish_test();
	end
endmodule
